// ### hw/drw_pin_sync.sv
// Two-stage pin synchroniser with a falling-edge pulse.
module drw_pin_sync #(
   parameter int W = 1
) (
   input wire logic clk_sys, // System clock.
   input wire logic rst_b, // Synchronous reset, active low.
   input wire logic clk_en, // Freezes state while low.
   input wire logic [W-1:0] pin, // Asynchronous pin levels.
   output logic [W-1:0] level, // Synchronised level.
   output logic [W-1:0] fall // One-cycle pulse per falling edge.
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
   } drw_sync_t;

   drw_sync_t s, next_s;

   always_comb begin
      next_s = s;
      next_s.s1 = pin;
      next_s.s2 = s.s1;
      next_s.s3 = s.s2;
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         s <= '1;
      end else if (clk_en) begin
         s <= next_s;
      end
   end

   // The first stage feeds only the second; the edge is taken between stages two and three.
   assign level = s.s2;
   assign fall = s.s3 & ~s.s2 & {W{clk_en}};
endmodule // drw_pin_sync

// ### hw/drw_regs.sv
// Derivative register bank: clock control, event counters, ports, RAM, wake logic.
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
module drw_regs (
   input wire logic clk_sys, // System clock, 50 MHz.
   input wire logic rst_b, // Synchronous reset, active low.
   input wire logic clk_en, // Clock enable; all state holds while low.
   input wire logic [drw_pkg::ADDR_W-1:0] s_axi_awaddr, // Write address.
   input wire logic s_axi_awvalid, // Write address valid.
   output logic s_axi_awready, // Write address ready.
   input wire logic [31:0] s_axi_wdata, // Write data.
   input wire logic [3:0] s_axi_wstrb, // Write byte strobes.
   input wire logic s_axi_wvalid, // Write data valid.
   output logic s_axi_wready, // Write data ready.
   output logic [1:0] s_axi_bresp, // Write response.
   output logic s_axi_bvalid, // Write response valid.
   input wire logic s_axi_bready, // Write response ready.
   input wire logic [drw_pkg::ADDR_W-1:0] s_axi_araddr, // Read address.
   input wire logic s_axi_arvalid, // Read address valid.
   output logic s_axi_arready, // Read address ready.
   output logic [31:0] s_axi_rdata, // Read data.
   output logic [1:0] s_axi_rresp, // Read response.
   output logic s_axi_rvalid, // Read data valid.
   input wire logic s_axi_rready, // Read data ready.
   input wire logic rtc_tick, // Clock interrupt event from the divider chain, one cycle.
   input wire logic cnt1_pin, // Counter one count input pin.
   input wire logic cnt2_pin, // Counter two count input pin.
   input wire logic external_interrupt_input_b, // External interrupt pin, active low.
   input wire logic core_idle, // Core is in Idle mode.
   input wire logic core_stop, // Core is in Stop mode.
   output logic ext_int_req, // Combined external interrupt request.
   output logic core_wake, // Release request for the core from Idle or Stop.
   output logic rtc_run, // Run bit to the divider chain.
   output logic [7:0] rtc_trim, // Frequency trim to the divider chain.
   output logic [7:0] port0_out, // Port 0 push-pull outputs.
   output logic [7:0] port0_oe_b, // Port 0 drive enables, low drives.
   input wire logic [7:0] port1_in, // Port 1 pin levels.
   output logic [7:0] port1_out, // Port 1 output levels.
   output logic [7:0] port1_oe_b // Port 1 drive enables, low drives.
);
   import drw_pkg::*;

   typedef struct packed {
      logic aw_held;
      logic [IDX_W-1:0] aw_idx;
      logic w_held;
      logic [7:0] w_byte;
      logic w_lane0;
      logic awready;
      logic wready;
      logic bvalid;
      logic arready;
      logic rvalid;
      logic [7:0] rdata;
      logic [7:0] clock_ctrl;
      logic [7:0] freq_trim;
      logic [7:0] cnt_ctrl;
      logic [15:0] cnt1;
      logic [15:0] cnt2;
      logic [7:0] port0;
      logic [7:0] port1;
      logic irq;
      logic wake;
      logic [RAM_BYTES-1:0][7:0] ram;
   } drw_state_t;

   drw_state_t s, next_s;
   logic [1:0] pin_level;
   logic [1:0] pin_fall;
   logic ext_level;
   logic [1:0] unused_fall;
   logic do_write;
   logic do_read;
   logic [IDX_W-1:0] ar_idx;
   logic c1_wrap;
   logic c2_wrap;

   drw_pin_sync #(.W(2)) u_cnt_sync (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .clk_en(clk_en),
      .pin({cnt2_pin, cnt1_pin}),
      .level(pin_level),
      .fall(pin_fall)
   );

   drw_pin_sync #(.W(1)) u_ext_sync (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .clk_en(clk_en),
      .pin(external_interrupt_input_b),
      .level(ext_level),
      .fall()
   );

   assign unused_fall = pin_level;

   function automatic logic is_ram(input logic [IDX_W-1:0] idx);
      return idx >= IDX_RAM_BASE && idx < IDX_RAM_BASE + IDX_W'(RAM_BYTES);
   endfunction

   function automatic logic [7:0] ram_off(input logic [IDX_W-1:0] idx);
      logic [IDX_W-1:0] d;
      d = idx - IDX_RAM_BASE;
      return d[7:0];
   endfunction

   // Counting halts on its own enable bit or while clk_en is low, never on the core's power mode.
   assign c1_wrap = pin_fall[0] && s.cnt_ctrl[PC_EC1] && s.cnt1 == 16'hFFFF;
   assign c2_wrap = pin_fall[1] && s.cnt_ctrl[PC_EC2] && s.cnt2 == 16'hFFFF;
   assign do_write = s.aw_held && s.w_held && !s.bvalid;
   assign do_read = s_axi_arvalid && s.arready;
   assign ar_idx = s_axi_araddr[ADDR_W-1:2];

   always_comb begin
      logic [IDX_W-1:0] wi;
      logic [7:0] wb;
      logic [7:0] rd;
      logic [7:0] cc_set;
      logic [7:0] pc_set;
      wi = s.aw_idx;
      wb = s.w_byte;
      rd = 8'h00;
      cc_set = 8'h00;
      pc_set = 8'h00;
      next_s = s;

      // Write address and data are taken independently and held until both are present.
      if (s_axi_awvalid && s.awready) begin
         next_s.aw_held = 1'b1;
         next_s.aw_idx = s_axi_awaddr[ADDR_W-1:2];
      end
      if (s_axi_wvalid && s.wready) begin
         next_s.w_held = 1'b1;
         next_s.w_byte = s_axi_wdata[7:0];
         next_s.w_lane0 = s_axi_wstrb[0];
      end
      if (s.bvalid && s_axi_bready) begin
         next_s.bvalid = 1'b0;
      end

      // Counting runs in every core mode; a software byte write in the same cycle wins.
      if (pin_fall[0] && s.cnt_ctrl[PC_EC1]) begin
         next_s.cnt1 = s.cnt1 + 16'h0001;
      end
      if (pin_fall[1] && s.cnt_ctrl[PC_EC2]) begin
         next_s.cnt2 = s.cnt2 + 16'h0001;
      end
      if (s.clock_ctrl[CC_RUN] && rtc_tick) begin
         cc_set[CC_CIF] = 1'b1;
      end
      if (c1_wrap && s.cnt_ctrl[PC_EC1I]) begin
         pc_set[PC_C1F] = 1'b1;
      end
      if (c2_wrap && s.cnt_ctrl[PC_EC2I]) begin
         pc_set[PC_C2F] = 1'b1;
      end

      if (do_write) begin
         next_s.aw_held = 1'b0;
         next_s.w_held = 1'b0;
         next_s.bvalid = 1'b1;
         if (s.w_lane0) begin
            unique case (wi)
               IDX_CLOCK_CTRL: next_s.clock_ctrl = wb;
               IDX_FREQ_TRIM: next_s.freq_trim = wb;
               IDX_CNT_CTRL: next_s.cnt_ctrl = wb & PC_WRITABLE;
               IDX_C1_LO: next_s.cnt1[7:0] = wb;
               IDX_C1_HI: next_s.cnt1[15:8] = wb;
               IDX_C2_LO: next_s.cnt2[7:0] = wb;
               IDX_C2_HI: next_s.cnt2[15:8] = wb;
               IDX_PORT0: next_s.port0 = wb;
               IDX_PORT1: next_s.port1 = wb;
               default: begin
                  if (is_ram(wi)) begin
                     next_s.ram[ram_off(wi)] = wb;
                  end
               end
            endcase
         end
      end
      // Hardware sets win over a software clear in the same cycle.
      next_s.clock_ctrl = next_s.clock_ctrl | cc_set;
      next_s.cnt_ctrl = next_s.cnt_ctrl | pc_set;

      next_s.awready = !next_s.aw_held && !next_s.bvalid;
      next_s.wready = !next_s.w_held && !next_s.bvalid;

      if (s.rvalid && s_axi_rready) begin
         next_s.rvalid = 1'b0;
      end
      if (do_read) begin
         unique case (ar_idx)
            IDX_CLOCK_CTRL: rd = s.clock_ctrl;
            IDX_FREQ_TRIM: rd = s.freq_trim;
            IDX_CNT_CTRL: rd = s.cnt_ctrl & PC_WRITABLE;
            IDX_C1_LO: rd = s.cnt1[7:0];
            IDX_C1_HI: rd = s.cnt1[15:8];
            IDX_C2_LO: rd = s.cnt2[7:0];
            IDX_C2_HI: rd = s.cnt2[15:8];
            IDX_PORT0: rd = s.port0;
            IDX_PORT1: rd = s.port1;
            IDX_PORT1_PINS: rd = port1_in;
            default: begin
               // Unused space and missing RAM read as zero.
               rd = is_ram(ar_idx) ? s.ram[ram_off(ar_idx)] : 8'h00;
            end
         endcase
         next_s.rvalid = 1'b1;
         next_s.rdata = rd;
      end
      next_s.arready = !next_s.rvalid;

      // Flags reach the interrupt line only through their enables.
      next_s.irq = (next_s.clock_ctrl[CC_CIF] && next_s.clock_ctrl[CC_ECI])
         || (next_s.cnt_ctrl[PC_C1F] && next_s.cnt_ctrl[PC_EC1I])
         || (next_s.cnt_ctrl[PC_C2F] && next_s.cnt_ctrl[PC_EC2I])
         || !ext_level;
      next_s.wake = (core_idle || core_stop) && next_s.irq;
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         s <= '0;
         s.port0 <= RST_PORT0;
         s.port1 <= RST_PORT1;
         s.clock_ctrl <= RST_REG;
         s.freq_trim <= RST_REG;
         s.cnt_ctrl <= RST_REG;
         s.cnt1 <= RST_COUNT;
         s.cnt2 <= RST_COUNT;
      end else if (clk_en) begin
         s <= next_s;
      end
   end

   assign s_axi_awready = s.awready;
   assign s_axi_wready = s.wready;
   assign s_axi_bvalid = s.bvalid;
   assign s_axi_bresp = RESP_OKAY;
   assign s_axi_arready = s.arready;
   assign s_axi_rvalid = s.rvalid;
   assign s_axi_rdata = {24'h000000, s.rdata};
   assign s_axi_rresp = RESP_OKAY;
   assign ext_int_req = s.irq;
   assign core_wake = s.wake;
   assign rtc_run = s.clock_ctrl[CC_RUN];
   assign rtc_trim = s.freq_trim;
   assign port0_out = s.port0;
   assign port0_oe_b = 8'h00;
   // Standard I/O drives low strongly and leaves a high to the pull-up.
   assign port1_out = s.port1;
   assign port1_oe_b = s.port1;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);

   property p_reset_clear;
      $past(!rst_b) |-> s.cnt_ctrl == 8'h00 && s.cnt1 == 16'h0000 && s.freq_trim == 8'h00;
   endproperty
   a_reset_clear: assert property (p_reset_clear) else $error("Registers not cleared by reset.");

   property p_port_reset;
      $past(!rst_b) |-> port0_out == 8'h0C && port1_out == 8'h8F;
   endproperty
   a_port_reset: assert property (p_port_reset) else $error("Port reset pattern wrong.");

   property p_port_dir;
      port0_oe_b == 8'h00 && port1_oe_b == port1_out;
   endproperty
   a_port_dir: assert property (p_port_dir) else $error("Port drive enables wrong.");

   property p_count;
      clk_en && pin_fall[0] && s.cnt_ctrl[PC_EC1] && !do_write |=> s.cnt1 == $past(s.cnt1) + 16'h0001;
   endproperty
   a_count: assert property (p_count) else $error("Counter one missed an edge.");

   property p_hold;
      clk_en && !s.cnt_ctrl[PC_EC2] && !do_write |=> $stable(s.cnt2);
   endproperty
   a_hold: assert property (p_hold) else $error("Disabled counter two moved.");

   property p_flag;
      clk_en && c1_wrap && s.cnt_ctrl[PC_EC1I] |=> s.cnt_ctrl[PC_C1F];
   endproperty
   a_flag: assert property (p_flag) else $error("Overflow flag not set.");

   property p_irq;
      s.cnt_ctrl[PC_C1F] && s.cnt_ctrl[PC_EC1I] |-> ext_int_req;
   endproperty
   a_irq: assert property (p_irq) else $error("Flag not on interrupt line.");

   property p_wake;
      clk_en && core_stop && s.clock_ctrl[CC_CIF] && s.clock_ctrl[CC_ECI] && !do_write |=> core_wake;
   endproperty
   a_wake: assert property (p_wake) else $error("Core not released from Stop.");

   property p_wake_idle;
      core_wake |-> $past(core_idle || core_stop) || !$past(clk_en);
   endproperty
   a_wake_idle: assert property (p_wake_idle) else $error("Wake without low-power mode.");

   property p_zero_bits;
      s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000;
   endproperty
   a_zero_bits: assert property (p_zero_bits) else $error("Upper read bits not zero.");

   property p_read_lat;
      do_read && clk_en |=> s_axi_rvalid;
   endproperty
   a_read_lat: assert property (p_read_lat) else $error("Read answer late.");

   property p_write_lat;
      clk_en && do_write |=> s_axi_bvalid;
   endproperty
   a_write_lat: assert property (p_write_lat) else $error("Write answer late.");

   c_wrap: cover property (c1_wrap && s.cnt_ctrl[PC_EC1I]);
   c_wake: cover property (core_idle ##1 core_wake);
   c_ram: cover property (do_write && is_ram(s.aw_idx));
endmodule // drw_regs

// ### shared/drw_pkg.sv
// Constants, register map and reset values for the derivative register bank.
package drw_pkg;
   localparam int ADDR_W = 11;
   localparam int IDX_W = 9;
   // Register indices; byte address is four times the index.
   localparam logic [IDX_W-1:0] IDX_CLOCK_CTRL = 9'h020;
   localparam logic [IDX_W-1:0] IDX_FREQ_TRIM = 9'h021;
   localparam logic [IDX_W-1:0] IDX_CNT_CTRL = 9'h040;
   localparam logic [IDX_W-1:0] IDX_C1_LO = 9'h041;
   localparam logic [IDX_W-1:0] IDX_C1_HI = 9'h042;
   localparam logic [IDX_W-1:0] IDX_C2_LO = 9'h043;
   localparam logic [IDX_W-1:0] IDX_C2_HI = 9'h044;
   localparam logic [IDX_W-1:0] IDX_PORT0 = 9'h050;
   localparam logic [IDX_W-1:0] IDX_PORT1 = 9'h051;
   localparam logic [IDX_W-1:0] IDX_PORT1_PINS = 9'h052;
   localparam logic [IDX_W-1:0] IDX_RAM_BASE = 9'h100;
   localparam int RAM_BYTES = 224;
   // Clock control fields.
   localparam int CC_RUN = 3;
   localparam int CC_CIF = 1;
   localparam int CC_ECI = 0;
   // Counter control fields.
   localparam int PC_EC1 = 7;
   localparam int PC_EC1I = 6;
   localparam int PC_C1F = 4;
   localparam int PC_EC2 = 3;
   localparam int PC_EC2I = 2;
   localparam int PC_C2F = 0;
   localparam logic [7:0] PC_WRITABLE = 8'hDD;
   // Reset values and the OKAY response code.
   localparam logic [7:0] RST_REG = 8'h00;
   localparam logic [15:0] RST_COUNT = 16'h0000;
   localparam logic [7:0] RST_PORT0 = 8'h0C;
   localparam logic [7:0] RST_PORT1 = 8'h8F;
   localparam logic [1:0] RESP_OKAY = 2'h0;
endpackage : drw_pkg

// ### tb/drw_core_model.sv
// Core-side bus master model that reaches the derivative registers.
module drw_core_model
   import drw_pkg::*;
(
   input wire logic clk_sys, // System clock.
   output logic [drw_pkg::ADDR_W-1:0] s_axi_awaddr, // Write address.
   output logic s_axi_awvalid, // Write address valid.
   input wire logic s_axi_awready, // Write address ready.
   output logic [31:0] s_axi_wdata, // Write data.
   output logic [3:0] s_axi_wstrb, // Write strobes.
   output logic s_axi_wvalid, // Write data valid.
   input wire logic s_axi_wready, // Write data ready.
   input wire logic [1:0] s_axi_bresp, // Write response.
   input wire logic s_axi_bvalid, // Write response valid.
   output logic s_axi_bready, // Write response ready.
   output logic [drw_pkg::ADDR_W-1:0] s_axi_araddr, // Read address.
   output logic s_axi_arvalid, // Read address valid.
   input wire logic s_axi_arready, // Read address ready.
   input wire logic [31:0] s_axi_rdata, // Read data.
   input wire logic [1:0] s_axi_rresp, // Read response.
   input wire logic s_axi_rvalid, // Read data valid.
   output logic s_axi_rready // Read data ready.
);
   timeunit 1ns;
   timeprecision 1ns;
   bit hung = 0;
   bit bad_resp = 0;
   initial begin
      {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
      s_axi_wstrb = 4'hF;
   end
   // Handshakes are judged at the falling edge, where the outputs of the
   // last rising edge are already settled, so no race with the slave.
   task automatic wr(input logic [8:0] idx, input logic [7:0] d);
      bit ha, hw, hb;
      @(posedge clk_sys);
      s_axi_awaddr <= {idx, 2'b00};
      s_axi_wdata <= {24'h000000, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (int n = 0; n < 64 && !hb; n++) begin
         @(negedge clk_sys);
         ha = s_axi_awvalid & s_axi_awready;
         hw = s_axi_wvalid & s_axi_wready;
         hb = s_axi_bvalid;
         if (hb && s_axi_bresp !== RESP_OKAY) bad_resp = 1;
         @(posedge clk_sys);
         if (ha) s_axi_awvalid <= 1'b0;
         if (hw) s_axi_wvalid <= 1'b0;
         if (hb) s_axi_bready <= 1'b0;
      end
      if (!hb) hung = 1;
   endtask
   task automatic rd(input logic [8:0] idx, output logic [7:0] d);
      bit ha, hr;
      d = 8'h00;
      @(posedge clk_sys);
      s_axi_araddr <= {idx, 2'b00};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (int n = 0; n < 64 && !hr; n++) begin
         @(negedge clk_sys);
         ha = s_axi_arvalid & s_axi_arready;
         hr = s_axi_rvalid;
         if (hr) d = s_axi_rdata[7:0];
         if (hr && s_axi_rresp !== RESP_OKAY) bad_resp = 1;
         @(posedge clk_sys);
         if (ha) s_axi_arvalid <= 1'b0;
         if (hr) s_axi_rready <= 1'b0;
      end
      if (!hr) hung = 1;
   endtask
endmodule // drw_core_model

// ### tb/tb_drw_regs.sv
// Self-checking testbench for the derivative register bank.
module tb_drw_regs
   import drw_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_sys = 0, rst_b = 0, clk_en = 1, rtc_tick = 0, cnt1_pin = 1, cnt2_pin = 1;
   logic external_interrupt_input_b = 1, core_idle = 0, core_stop = 0;
   logic [7:0] port1_in = 8'hA5;
   logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic ext_int_req, core_wake, rtc_run;
   logic [7:0] rtc_trim, port0_out, port0_oe_b, port1_out, port1_oe_b;
   int fails = 0, total_checks = 0;
   // Each row: register index, value written, value read back.
   localparam logic [24:0] ROWS [0:14] = '{
      {9'h020, 8'hA5, 8'hA5}, {9'h021, 8'h3C, 8'h3C}, {9'h040, 8'h22, 8'h00},
      {9'h040, 8'h99, 8'h99}, {9'h041, 8'h12, 8'h12}, {9'h042, 8'h34, 8'h34},
      {9'h043, 8'h56, 8'h56}, {9'h044, 8'h78, 8'h78}, {9'h030, 8'hFF, 8'h00},
      {9'h045, 8'hFF, 8'h00}, {9'h100, 8'h5A, 8'h5A}, {9'h1DF, 8'hA5, 8'hA5},
      {9'h1E0, 8'h77, 8'h00}, {9'h050, 8'h5A, 8'h5A}, {9'h051, 8'h3C, 8'h3C}};
   localparam logic [8:0] REGS [0:6] = '{9'h020, 9'h021, 9'h040, 9'h041, 9'h042, 9'h043, 9'h044};

   drw_regs i_drw_regs (.*);
   drw_core_model i_drw_core_model (.*);

   always #10 clk_sys = ~clk_sys;

   task automatic stop_test;
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("FAIL %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic w(input logic [8:0] i, input logic [7:0] d);
      i_drw_core_model.wr(i, d);
      if (i_drw_core_model.hung) begin
         fails++;
         stop_test();
      end
   endtask
   task automatic rc(input logic [8:0] i, input logic [7:0] e);
      logic [7:0] v;
      i_drw_core_model.rd(i, v);
      if (i_drw_core_model.hung) begin
         fails++;
         stop_test();
      end
      chk(v, e);
   endtask
   task automatic do_reset;
      rst_b <= 1'b0;
      repeat (8) @(posedge clk_sys);
      rst_b <= 1'b1;
      repeat (2) @(posedge clk_sys);
   endtask
   // Low phase of three cycles keeps the synchroniser from missing the edge.
   task automatic pulse(input bit two);
      if (two) cnt2_pin <= 1'b0; else cnt1_pin <= 1'b0;
      repeat (3) @(posedge clk_sys);
      cnt1_pin <= 1'b1;
      cnt2_pin <= 1'b1;
      repeat (6) @(posedge clk_sys);
   endtask
   function automatic logic [7:0] b(input logic v);
      return {7'h00, v};
   endfunction

   initial begin
      @(posedge clk_sys);
      do_reset();
      foreach (ROWS[k]) begin
         w(ROWS[k][24:16], ROWS[k][15:8]);
         rc(ROWS[k][24:16], ROWS[k][7:0]);
      end
      rc(9'h052, 8'hA5);
      chk(rtc_trim, 8'h3C);
      // A second reset in mid-run must clear the seven clock and counter registers written above and restore the port reset patterns.
      do_reset();
      foreach (REGS[k]) rc(REGS[k], 8'h00);
      chk(port0_out, 8'h0C);
      chk(port1_out, 8'h8F);
      chk(port0_oe_b, 8'h00);
      chk(port1_oe_b, 8'h8F);
      w(9'h040, 8'hC0);
      w(9'h041, 8'hFF);
      w(9'h042, 8'hFF);
      pulse(0);
      rc(9'h041, 8'h00);
      rc(9'h042, 8'h00);
      rc(9'h040, 8'hD0);
      chk(b(ext_int_req), 8'h01);
      core_stop <= 1'b1;
      repeat (3) @(posedge clk_sys);
      chk(b(core_wake), 8'h01);
      core_stop <= 1'b0;
      core_idle <= 1'b1;
      repeat (3) @(posedge clk_sys);
      chk(b(core_wake), 8'h01);
      w(9'h040, 8'hC0);
      repeat (3) @(posedge clk_sys);
      chk(b(ext_int_req), 8'h00);
      chk(b(core_wake), 8'h00);
      pulse(0);
      rc(9'h041, 8'h01);
      core_idle <= 1'b0;
      core_stop <= 1'b1;
      w(9'h040, 8'h08);
      pulse(1);
      rc(9'h043, 8'h01);
      w(9'h040, 8'h00);
      pulse(1);
      rc(9'h043, 8'h01);
      w(9'h020, 8'h09);
      chk(b(rtc_run), 8'h01);
      rtc_tick <= 1'b1;
      @(posedge clk_sys);
      rtc_tick <= 1'b0;
      repeat (3) @(posedge clk_sys);
      chk(b(core_wake), 8'h01);
      rc(9'h020, 8'h0B);
      w(9'h020, 8'h00);
      core_stop <= 1'b0;
      external_interrupt_input_b <= 1'b0;
      repeat (6) @(posedge clk_sys);
      chk(b(ext_int_req), 8'h01);
      // A frozen block must miss a whole pin pulse, then count the next one.
      w(9'h040, 8'h80);
      clk_en <= 1'b0;
      pulse(0);
      clk_en <= 1'b1;
      rc(9'h041, 8'h01);
      pulse(0);
      rc(9'h041, 8'h02);
      chk(b(i_drw_core_model.bad_resp), 8'h00);
      stop_test();
   end
endmodule // tb_drw_regs
